// ===== smsp_consts.vh
/*
 Constants of the serial master/slave port: register byte offsets,
 field positions, reset values and bus response codes.
 Assumes it is included by bare name from the top design file, the checker and the bench.
*/
`ifndef SMSP_CONSTS_VH
`define SMSP_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------
`define SMSP_ADDR_W      8
`define SMSP_ADDR_DATA   8'h00
`define SMSP_ADDR_CTRL   8'h04
`define SMSP_ADDR_CONFIG 8'h08
`define SMSP_ADDR_CLKDIV 8'h0C
`define SMSP_ADDR_STATUS 8'h10
`define SMSP_ADDR_MASK   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMSP_CTRL_ENABLE 0
`define SMSP_CTRL_MASTER 1
`define SMSP_CTRL_MODE_FAULT_DETECT_ENABLE  2
`define SMSP_CTRL_BUSY   7
`define SMSP_CFG_CPOL    0
`define SMSP_CFG_CPHA    1
`define SMSP_CFG_CHAR16  2
`define SMSP_ST_DONE     0
`define SMSP_ST_OVERRUN  1
`define SMSP_ST_WRITE_COLLISION_FLAG     2
`define SMSP_ST_MODE_FAULT_FLAG     3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SMSP_DIV_RST     8'h03
`define SMSP_SYNC_RST    4'h8
`define SMSP_LAST_EDGE8  5'h0F
`define SMSP_LAST_EDGE16 5'h1F
`define SMSP_RESP_OKAY   2'h0
`define SMSP_RESP_SLVERR 2'h2

`endif

// ===== smsp_sync.v
/*
 Three-stage pin synchroniser, one lane per bit.
 Assumes inputs are asynchronous to clk; the output changes only
 once the second and third stages agree.
*/
`timescale 1ns/1ps

module smsp_sync #(
   parameter       WIDTH     = 4,
   parameter [3:0] RESET_VAL = 4'h0
)(
   input  wire             clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   genvar i;

   // ----------------------------------------------------------------
   // Per-bit lanes
   // ----------------------------------------------------------------
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : lane
         reg s1_reg;
         reg s2_reg;
         reg s3_reg;
         reg out_reg;
         // First stage feeds only the second; agreement filters glitches
         always @(posedge clk or posedge reset)
         begin
            if (reset)
            begin
               s1_reg  <= RESET_VAL[i];
               s2_reg  <= RESET_VAL[i];
               s3_reg  <= RESET_VAL[i];
               out_reg <= RESET_VAL[i];
            end
            else
            begin
               s1_reg <= async_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
                  out_reg <= s3_reg;
            end
         end
         assign sync_out[i] = out_reg;
      end
   endgenerate

endmodule // smsp_sync

// ===== smsp_baud_div.v
/*
 Baud divider: one-cycle tick every divisor+1 clocks while run is high.
 Assumes run drops between transfers so each frame starts in phase.
*/
`timescale 1ns/1ps

module smsp_baud_div (
   input  wire       clk,
   input  wire       reset,
   input  wire       run,
   input  wire [7:0] divisor,
   output reg        tick
);

   reg [7:0] cnt_reg;

   // ----------------------------------------------------------------
   // Counter; held at zero while idle
   // ----------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_reg <= 8'h00;
         tick    <= 1'b0;
      end
      else if (!run)
      begin
         cnt_reg <= 8'h00;
         tick    <= 1'b0;
      end
      else if (cnt_reg == divisor)
      begin
         cnt_reg <= 8'h00;
         tick    <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 8'h01;
         tick    <= 1'b0;
      end
   end

endmodule // smsp_baud_div

// ===== smsp_top.v
/*
 Serial master/slave port with AXI4-Lite register access.
 Assumes serial pins are asynchronous to clk and are sampled here;
 the pin wire levels are resolved outside from the *_oe_n enables.
*/
// What this block does
// - Full duplex four-wire port, master or slave
// - Character length 8 or 16 bits
// - Four clock polarity and phase combinations
// - Slave clock up to 1/8, master 1/2
// - Completed character copied into read buffer
// - No overrun if buffer read in time
// - Transmit single buffered, load only when idle
// - One data address: read buffer, write shifter
// - Master samples MISO; selected slave drives it
// - Master drives MOSI; selected slave samples it
// - Master makes SCLK; slave shifts on it
// - SS selects slave, or faults master if enabled
// - Completion and errors flagged for irq or polling
// - Busy flag set during transfer, read only
// - Data write while busy blocked, collision flagged
// - Overrun flagged, newest character discarded
// - SS fall in master faults, clears master
`timescale 1ns/1ps
`include "smsp_consts.vh"

module smsp_top (
   input  wire        clk,
   input  wire        reset,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        sclk_in,
   output reg         sclk_out,
   output reg         sclk_oe_n,
   input  wire        mosi_in,
   output wire        mosi_out,
   output reg         mosi_oe_n,
   input  wire        miso_in,
   output wire        miso_out,
   output reg         miso_oe_n,
   input  wire        ss_n,
   output reg         irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [7:0]  aw_addr_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg         enable_reg;
   reg         master_reg;
   reg         mode_fault_detect_enable_reg;
   reg         cpol_reg;
   reg         cpha_reg;
   reg         char16_reg;
   reg  [7:0]  div_reg;
   reg  [3:0]  status_reg;
   reg  [3:0]  mask_reg;
   reg  [15:0] rbuf_reg;
   reg         rbuf_full_reg;
   reg  [15:0] sh_reg;
   reg         shift_out_reg;
   reg         busy_reg;
   reg  [4:0]  edge_cnt_reg;
   reg         sclk_prev_reg;
   reg         ss_prev_reg;
   reg  [31:0] rd_data;
   reg         rd_err;
   reg         wr_err;
   wire [3:0]  pins_s;
   wire        tick;

   // Pin sampling: {ss_n, miso, mosi, sclk}
   smsp_sync #(
      .WIDTH     (4),
      .RESET_VAL (`SMSP_SYNC_RST)
   ) u_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in ({ss_n, miso_in, mosi_in, sclk_in}),
      .sync_out (pins_s)
   );

   // Half period divisor+1 clocks; MISO sync lag needs divisor >= 4
   smsp_baud_div u_baud (
      .clk     (clk),
      .reset   (reset),
      .run     (busy_reg & master_reg),
      .divisor (div_reg),
      .tick    (tick)
   );

   wire sclk_s = pins_s[0];
   wire mosi_s = pins_s[1];
   wire miso_s = pins_s[2];
   wire ss_s   = pins_s[3];

   // ----------------------------------------------------------------
   // Bus decode helpers
   // ----------------------------------------------------------------
   wire do_wr   = !s_axi_awready & !s_axi_wready & !s_axi_bvalid;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire wr_lo   = do_wr & w_strb_reg[0];
   wire [15:0] wr_word = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
                          w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
   wire wr_data_hit = do_wr & (aw_addr_reg == `SMSP_ADDR_DATA);
   wire rd_data_hit = ar_take & (s_axi_araddr == `SMSP_ADDR_DATA);

   // ----------------------------------------------------------------
   // Shift engine helpers
   // ----------------------------------------------------------------
   wire collide   = wr_data_hit & busy_reg;
   wire load      = wr_data_hit & !busy_reg & enable_reg;
   wire ss_fall   = ss_prev_reg & !ss_s;
   wire fault     = ss_fall & enable_reg & master_reg & mode_fault_detect_enable_reg;
   wire sel_start = ss_fall & enable_reg & !master_reg & !busy_reg;
   wire m_edge    = tick & busy_reg & master_reg;
   wire s_edge    = busy_reg & !master_reg & !ss_s & (sclk_s != sclk_prev_reg);
   wire eng_edge  = m_edge | s_edge;
   // Leading edge leaves the idle level set by polarity
   wire lead      = master_reg ? (sclk_out == cpol_reg) : (sclk_s != cpol_reg);
   wire sample    = lead ^ cpha_reg;
   wire in_bit    = master_reg ? miso_s : mosi_s;
   wire [15:0] sh_shift = {sh_reg[14:0], in_bit};
   wire last_edge = edge_cnt_reg ==
                    (char16_reg ? `SMSP_LAST_EDGE16 : `SMSP_LAST_EDGE8);
   wire done      = eng_edge & last_edge;
   wire [15:0] rx_raw  = sample ? sh_shift : sh_reg;
   wire [15:0] rx_word = char16_reg ? rx_raw : {8'h00, rx_raw[7:0]};
   wire store     = done & (!rbuf_full_reg | rd_data_hit);
   wire overrun   = done & rbuf_full_reg & !rd_data_hit;
   wire [3:0] events = {fault, collide, overrun, done};

   // Outgoing bit is MSB of the active character width
   function msb_of;
      input [15:0] v;
      input        wide;
      begin
         msb_of = wide ? v[15] : v[7];
      end
   endfunction

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (s_axi_araddr == `SMSP_ADDR_DATA)
         rd_data = {16'h0000, rbuf_reg};
      else if (s_axi_araddr == `SMSP_ADDR_CTRL)
         rd_data = {24'h00_0000, busy_reg, 4'h0,
                    mode_fault_detect_enable_reg, master_reg, enable_reg};
      else if (s_axi_araddr == `SMSP_ADDR_CONFIG)
         rd_data = {29'h0000_0000, char16_reg, cpha_reg, cpol_reg};
      else if (s_axi_araddr == `SMSP_ADDR_CLKDIV)
         rd_data = {24'h00_0000, div_reg};
      else if (s_axi_araddr == `SMSP_ADDR_STATUS)
         rd_data = {28'h000_0000, status_reg};
      else if (s_axi_araddr == `SMSP_ADDR_MASK)
         rd_data = {28'h000_0000, mask_reg};
      else
         rd_err = 1'b1;
   end

   // Write address check; unmapped writes answer SLVERR
   always @*
   begin
      wr_err = 1'b0;
      if (aw_addr_reg == `SMSP_ADDR_DATA)
         wr_err = 1'b0;
      else if (aw_addr_reg == `SMSP_ADDR_CTRL)
         wr_err = 1'b0;
      else if (aw_addr_reg == `SMSP_ADDR_CONFIG)
         wr_err = 1'b0;
      else if (aw_addr_reg == `SMSP_ADDR_CLKDIV)
         wr_err = 1'b0;
      else if (aw_addr_reg == `SMSP_ADDR_STATUS)
         wr_err = 1'b0;
      else if (aw_addr_reg == `SMSP_ADDR_MASK)
         wr_err = 1'b0;
      else
         wr_err = 1'b1;
   end

   // ----------------------------------------------------------------
   // AXI4-Lite handshakes: address and data held until response taken
   // ----------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SMSP_RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `SMSP_RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         aw_addr_reg   <= 8'h00;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY;
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         // Read answers one cycle after the address is taken
         if (ar_take)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_err ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY;
         end
         if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Control registers and sticky flags (set beats write-one clear)
   // ----------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         enable_reg <= 1'b0;
         master_reg <= 1'b0;
         mode_fault_detect_enable_reg  <= 1'b0;
         cpol_reg   <= 1'b0;
         cpha_reg   <= 1'b0;
         char16_reg <= 1'b0;
         div_reg    <= `SMSP_DIV_RST;
         status_reg <= 4'h0;
         mask_reg   <= 4'h0;
         irq        <= 1'b0;
      end
      else
      begin
         if (wr_lo & (aw_addr_reg == `SMSP_ADDR_CTRL))
         begin
            enable_reg <= w_data_reg[`SMSP_CTRL_ENABLE];
            mode_fault_detect_enable_reg  <= w_data_reg[`SMSP_CTRL_MODE_FAULT_DETECT_ENABLE];
            // Promotion to master only while SS is deasserted
            master_reg <= w_data_reg[`SMSP_CTRL_MASTER] & (master_reg | ss_s);
         end
         if (wr_lo & (aw_addr_reg == `SMSP_ADDR_CONFIG))
         begin
            cpol_reg   <= w_data_reg[`SMSP_CFG_CPOL];
            cpha_reg   <= w_data_reg[`SMSP_CFG_CPHA];
            char16_reg <= w_data_reg[`SMSP_CFG_CHAR16];
         end
         if (wr_lo & (aw_addr_reg == `SMSP_ADDR_CLKDIV))
            div_reg <= w_data_reg[7:0];
         if (wr_lo & (aw_addr_reg == `SMSP_ADDR_MASK))
            mask_reg <= w_data_reg[3:0];
         if (fault)
            master_reg <= 1'b0;
         if (wr_lo & (aw_addr_reg == `SMSP_ADDR_STATUS))
            status_reg <= (status_reg & ~w_data_reg[3:0]) | events;
         else
            status_reg <= status_reg | events;
         irq <= |(status_reg & mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // Shift engine, receive buffer and pin drivers
   // ----------------------------------------------------------------
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sh_reg        <= 16'h0000;
         shift_out_reg <= 1'b0;
         busy_reg      <= 1'b0;
         edge_cnt_reg  <= 5'h00;
         rbuf_reg      <= 16'h0000;
         rbuf_full_reg <= 1'b0;
         sclk_prev_reg <= 1'b0;
         ss_prev_reg   <= 1'b1;
         sclk_out      <= 1'b0;
         sclk_oe_n     <= 1'b1;
         mosi_oe_n     <= 1'b1;
         miso_oe_n     <= 1'b1;
      end
      else
      begin
         sclk_prev_reg <= sclk_s;
         ss_prev_reg   <= ss_s;
         // Write goes to the shifter; a collision leaves it untouched
         if (load)
         begin
            sh_reg <= wr_word;
            if (!cpha_reg)
               shift_out_reg <= msb_of(wr_word, char16_reg);
            if (master_reg)
            begin
               busy_reg     <= 1'b1;
               edge_cnt_reg <= 5'h00;
            end
         end
         // Slave frame starts at select
         if (sel_start & !load)
         begin
            busy_reg     <= 1'b1;
            edge_cnt_reg <= 5'h00;
            if (!cpha_reg)
               shift_out_reg <= msb_of(sh_reg, char16_reg);
         end
         if (eng_edge)
         begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
            if (sample)
               sh_reg <= sh_shift;
            else
               shift_out_reg <= msb_of(sh_reg, char16_reg);
            if (last_edge)
               busy_reg <= 1'b0;
         end
         // Deselect ends a slave frame; a fault ends a master frame
         if ((busy_reg & !master_reg & ss_s) | fault)
            busy_reg <= 1'b0;
         if (store)
         begin
            rbuf_reg      <= rx_word;
            rbuf_full_reg <= 1'b1;
         end
         else if (rd_data_hit)
            rbuf_full_reg <= 1'b0;
         // Master clock rests at polarity level between frames
         if (!busy_reg | !master_reg)
            sclk_out <= cpol_reg;
         else if (m_edge)
            sclk_out <= ~sclk_out;
         sclk_oe_n <= !(enable_reg & master_reg);
         mosi_oe_n <= !(enable_reg & master_reg);
         miso_oe_n <= !(enable_reg & !master_reg & !ss_s);
      end
   end

   // Both data pins carry the same shifter bit; enables pick the pin
   assign mosi_out = shift_out_reg;
   assign miso_out = shift_out_reg;

endmodule // smsp_top

// ===== smsp_top_assertions.sv
/*
 Checker for the port: bus answers and serial pin enables.
 Assumes a bind to smsp_top; sees only its ports.
*/
`timescale 1ns/1ps
`include "smsp_consts.vh"

module smsp_chk (
   input wire        clk,
   input wire        reset,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        sclk_oe_n,
   input wire        mosi_oe_n,
   input wire        miso_oe_n,
   input wire        ss_n
);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready
      ##1 s_axi_bvalid) else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read response late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `SMSP_RESP_SLVERR
      |-> s_axi_rdata == 32'h0000_0000) else $error("error read not zero");

   // ----------------------------------------------------------------
   // Serial pins
   // ----------------------------------------------------------------
   chk_master_pins: assert property (sclk_oe_n == mosi_oe_n)
      else $error("master pins not driven together");
   chk_one_driver: assert property (miso_oe_n || mosi_oe_n)
      else $error("miso and mosi both driven");
   chk_miso_release: assert property (ss_n [*6] |=> miso_oe_n)
      else $error("miso driven while unselected");
   chk_miso_select: assert property ($fell(miso_oe_n)
      |-> !ss_n && !$past(ss_n) && !$past(ss_n, 2)) else $error("miso driven without select");
endmodule // smsp_chk

bind smsp_top smsp_chk u_chk (.*);

// ===== smsp_peer.sv
/*
 Far side of the link: slave for a master port, mode-0 master
 with a 160 ns clock for a slave port. Assumes the bench resolves pins.
*/
`timescale 1ns/1ps

module smsp_peer (
   input  wire  sclk_w,
   input  wire  mosi_w,
   input  wire  miso_w,
   input  wire  sel_n,
   output logic miso_p,
   output logic miso_p_oe_n,
   output logic sclk_m,
   output logic mosi_m,
   output logic ss_m
);
   logic [15:0] txd;
   logic [15:0] rxd;
   logic        cpol;
   logic        cpha;
   logic        mbit;
   int          k;

   // Idle master: clock stands still, no select
   initial
   begin
      sclk_m = 1'b0; ss_m = 1'b1; mbit = 1'b0;
      txd = 16'h0000; rxd = 16'h0000; cpol = 1'b0; cpha = 1'b0; k = 0;
   end

   // Slave drives miso only while selected, MSB first
   assign miso_p_oe_n = sel_n;
   assign miso_p      = txd[15 - (k < 0 ? 0 : k)];
   // Released mosi shows the inverse, never a stale level
   assign mosi_m      = ss_m ? ~mbit : mbit;

   // Cpha 1 drives its first bit on the leading edge
   always @(negedge sel_n) k = cpha ? -1 : 0;

   // Drive on one edge, sample mosi on the other
   always @(sclk_w)
      if (!sel_n)
      begin
         if ((sclk_w != cpol) == cpha) k = k + 1;
         else rxd = {rxd[14:0], mosi_w};
      end

   task load(input logic [15:0] d, input logic pol, input logic pha);
      txd = d; cpol = pol; cpha = pha;
   endtask

   task set_ss(input logic v);
      ss_m <= v;
   endtask

   // Mode 0 master frame, 8 bits, 160 ns clock period
   task mxfer(input logic [7:0] d, output logic [7:0] r);
      int i;
      r = 8'h00;
      #3 mbit = d[7];
      ss_m = 1'b0;
      for (i = 7; i >= 0; i--)
      begin
         mbit = d[i];
         #80 sclk_m = 1'b1;
         r = {r[6:0], miso_w};
         #80 sclk_m = 1'b0;
      end
      #80 ss_m = 1'b1;
   endtask
endmodule // smsp_peer

// ===== spi_master_slave_port_test.sv
/*
 Bench for the serial port: registers, master modes, errors, slave.
 Assumes design, peer and bound checker are compiled with it.
*/
`timescale 1ns/1ps
`include "smsp_consts.vh"

module spi_master_slave_port_test;
   localparam [7:0] A_DATA = `SMSP_ADDR_DATA;
   localparam [7:0] A_CTRL = `SMSP_ADDR_CTRL;
   localparam [7:0] A_CFG  = `SMSP_ADDR_CONFIG;
   localparam [7:0] A_DIV  = `SMSP_ADDR_CLKDIV;
   localparam [7:0] A_ST   = `SMSP_ADDR_STATUS;
   localparam [7:0] A_MSK  = `SMSP_ADDR_MASK;

   logic clk = 1'b0, reset = 1'b1, irq, sel_n = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
   logic miso_p, miso_p_oe_n, sclk_m, mosi_m, ss_m;
   wire  sclk_w, mosi_w, miso_w;
   int   num_errors = 0, compares = 0, cyc = 0;

   always #5 clk = ~clk;

   // Pin levels; an undriven miso toggles with the clock
   assign sclk_w = sclk_oe_n ? sclk_m : sclk_out;
   assign mosi_w = mosi_oe_n ? mosi_m : mosi_out;
   assign miso_w = !miso_oe_n ? miso_out : !miso_p_oe_n ? miso_p : clk;

   smsp_top u_dut (.*, .sclk_in(sclk_w), .mosi_in(mosi_w), .miso_in(miso_w), .ss_n(ss_m));

   smsp_peer u_peer (.*);

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp; s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask

   // Master frame; optional write while busy
   task mx(input logic [15:0] d, input logic col, input logic clr, output logic [31:0] st);
      logic [31:0] v;
      logic [1:0]  r;
      sel_n <= 1'b0;
      wr(A_DATA, d, r);
      rd(A_CTRL, v, r);
      chk("busy", 1'h1, v[`SMSP_CTRL_BUSY]);
      if (col) wr(A_DATA, 16'hFFFF, r);
      for (int t = 0; t < 400 && v[`SMSP_CTRL_BUSY]; t++) rd(A_CTRL, v, r);
      sel_n <= 1'b1;
      rd(A_ST, st, r);
      if (clr) wr(A_ST, st, r);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      rd(A_CTRL, d, r); chk("ctrl reset", 8'h00, d);
      rd(A_DIV, d, r); chk("clkdiv reset", `SMSP_DIV_RST, d);
      rd(A_ST, d, r); chk("status reset", 8'h00, d);
      rd(8'h18, d, r); chk("unmapped rresp", `SMSP_RESP_SLVERR, r);
      wr(8'h18, 8'h01, r); chk("unmapped bresp", `SMSP_RESP_SLVERR, r);
      wr(A_CTRL, 8'h80, r); rd(A_CTRL, d, r); chk("busy read only", 8'h00, d);
   endtask

   // Four modes at 8 bits, then 16 bits; divisors from 4 up
   task t_master;
      logic [31:0] st, d;
      logic [15:0] pv, td, msk;
      logic [1:0]  r;
      wr(A_CTRL, 8'h03, r);
      for (int m = 0; m < 5; m++)
      begin
         pv = 16'h3C5A ^ (m << 12); td = 16'h9AE1 ^ m[15:0];
         msk = (m == 4) ? 16'hFFFF : 16'h00FF;
         u_peer.load(pv, m[0], m[1]);
         wr(A_CFG, m, r); wr(A_DIV, m + 4, r);
         mx(td, m == 3, 1'b1, st);
         chk("done", 1'h1, st[`SMSP_ST_DONE]);
         chk("collision", m == 3, st[`SMSP_ST_WRITE_COLLISION_FLAG]);
         chk("no overrun", 1'h0, st[`SMSP_ST_OVERRUN]);
         rd(A_DATA, d, r); chk("master rx", (m == 4) ? pv : pv[15:8], d);
         chk("peer rx", td & msk, u_peer.rxd & msk);
      end
   endtask

   task t_ovr_irq;
      logic [31:0] st, d;
      logic [1:0]  r;
      wr(A_CFG, 8'h00, r); wr(A_MSK, 8'h01, r);
      u_peer.load(16'hA500, 1'b0, 1'b0); mx(16'h0011, 1'b0, 1'b0, st);
      chk("irq raised", 1'h1, irq);
      wr(A_MSK, 8'h00, r); chk("irq masked", 1'h0, irq);
      wr(A_MSK, 8'h01, r); wr(A_ST, 8'h01, r); chk("irq cleared", 1'h0, irq);
      u_peer.load(16'h5A00, 1'b0, 1'b0); mx(16'h0022, 1'b0, 1'b1, st);
      chk("overrun", 1'h1, st[`SMSP_ST_OVERRUN]);
      rd(A_DATA, d, r); chk("first kept", 8'hA5, d);
   endtask

   // Select ignored without fault detect, a fault with it
   task t_mode_fault_flag;
      logic [31:0] d;
      logic [1:0]  r;
      for (int fe = 0; fe < 2; fe++)
      begin
         wr(A_CTRL, 8'h03 | (fe << 2), r);
         u_peer.set_ss(1'b0);
         repeat (8) @(posedge clk);
         rd(A_ST, d, r); chk("mode fault", fe, d[`SMSP_ST_MODE_FAULT_FLAG]);
         rd(A_CTRL, d, r); chk("master bit", !fe, d[`SMSP_CTRL_MASTER]);
         u_peer.set_ss(1'b1);
         repeat (8) @(posedge clk);
         wr(A_ST, 8'h08, r);
      end
   endtask

   task t_slave;
      logic [31:0] d;
      logic [7:0]  pr;
      logic [1:0]  r;
      wr(A_CTRL, 8'h01, r); wr(A_CFG, 8'h00, r);
      chk("miso idle", 1'h1, miso_oe_n);
      wr(A_DATA, 8'hA5, r);
      u_peer.mxfer(8'h3C, pr);
      @(posedge clk);
      chk("slave tx", 8'hA5, pr);
      repeat (8) @(posedge clk);
      chk("miso released", 1'h1, miso_oe_n);
      rd(A_DATA, d, r); chk("slave rx", 8'h3C, d);
   endtask

   task final_report;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         final_report;
      end
   end

   // Main sequence
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      t_regs;
      t_master;
      t_ovr_irq;
      t_mode_fault_flag;
      t_slave;
      final_report;
   end
endmodule // spi_master_slave_port_test
